// ===== rtl/sram_cfg.svh
/*
 * Constants of the burst SRAM model: widths, depth and pacing counts.
 * Assumes it is included by bare name; the guard allows repeated inclusion.
 */
`ifndef SRAM_CFG_SVH
`define SRAM_CFG_SVH

// ============================================================
// widths and depth
`define ADDR_W        19
`define WORD_W        18
`define BYTE_W        9
`define BE_W          2
`define MEM_AW        21
`define MEM_DEPTH     2097152
`define PIN_W         46

// ============================================================
// pacing counts, in rises of the positive input clock
`define CNT_W         10
`define DLL_LOCK_K    1024
`define IMP_UPD_K     1024
`define DLL_LOCK_LAST (10'(`DLL_LOCK_K - 1))
`define IMP_UPD_LAST  (10'(`IMP_UPD_K - 1))

// ============================================================
// buffer
`define BUF_DEPTH     2'h2

`endif

// ===== rtl/sram_pkg.sv
/*
 * Types of the burst SRAM model: pin bundle, access slots, buffered
 * write words and the whole registered state of the top module.
 * Assumes sram_cfg.svh is on the include path.
 */
`include "sram_cfg.svh"

package sram_pkg;

    // ============================================================
    // pin bundle, sampled as one vector through the synchroniser
    typedef struct packed {
        logic                k;
        logic                k_n;
        logic                c;
        logic                c_n;
        logic                read_port_select_n;
        logic                write_port_select_n;
        logic                dll_disable_n;
        logic [`BE_W-1:0]    byte_write_select_n;
        logic [`ADDR_W-1:0]  addr;
        logic [`WORD_W-1:0]  d;
    } pins_t;

    // gray along idle -> read -> write -> read
    typedef enum logic [1:0] {
        OP_IDLE  = 2'b00,
        OP_READ  = 2'b01,
        OP_WRITE = 2'b11
    } last_op_t;

    typedef struct packed {
        logic                valid;
        logic                armed;
        logic                started;
        logic [1:0]          idx;
        logic [`ADDR_W-1:0]  addr;
    } rd_slot_t;

    typedef struct packed {
        logic                valid;
        logic [1:0]          idx;
        logic [`ADDR_W-1:0]  addr;
    } wr_slot_t;

    typedef struct packed {
        logic [`MEM_AW-1:0]  addr;
        logic [`BE_W-1:0]    be;
        logic [`WORD_W-1:0]  data;
    } wr_word_t;

    // ============================================================
    // complete state of the top module
    typedef struct packed {
        pins_t               s1;
        pins_t               s2;
        logic                k_q;
        logic                k_n_q;
        logic                c_q;
        logic                c_n_q;
        logic                single_mode;
        last_op_t            last_op;
        rd_slot_t            rd0;
        rd_slot_t            rd1;
        wr_slot_t            wr0;
        wr_slot_t            wr1;
        wr_word_t            buf0;
        wr_word_t            buf1;
        logic [1:0]          buf_cnt;
        logic                emit;
        logic                q_oe;
        logic [`WORD_W-1:0]  q;
        logic                echo;
        logic                echo_n;
        logic [`CNT_W-1:0]   dll_cnt;
        logic                dll_locked;
        logic [`CNT_W-1:0]   imp_cnt;
        logic                imp_pulse;
    } state_t;

endpackage

// ===== rtl/sram_array.sv
/*
 * Storage array: one port, byte-lane writes, registered read data.
 * Assumes the caller never reads and writes in the same cycle.
 */
`timescale 1ns/1ps
`include "sram_cfg.svh"

module sram_array (
    input  wire logic                i_clk,
    input  wire logic                i_en,
    input  wire logic                i_we,
    input  wire logic [`MEM_AW-1:0]  i_addr,
    input  wire logic [`BE_W-1:0]    i_be,
    input  wire logic [`WORD_W-1:0]  i_wdata,
    output logic      [`WORD_W-1:0]  o_rdata
);

    logic [`WORD_W-1:0] mem [0:`MEM_DEPTH-1];

    // ============================================================
    // write lanes that are enabled, else fetch into the read register
    always_ff @(posedge i_clk)
    begin
        if (i_en && i_we)
        begin
            for (int b = 0; b < `BE_W; b++)
            begin
                if (i_be[b])
                begin
                    mem[i_addr][b*`BYTE_W +: `BYTE_W] <= i_wdata[b*`BYTE_W +: `BYTE_W];
                end
            end
        end
        else if (i_en)
        begin
            o_rdata <= mem[i_addr];
        end
    end

endmodule

// ===== rtl/sram_burst.sv
/*
 * Burst SRAM core with separate read and write ports on one address bus.
 * Assumes every pin, the link clocks among them, is asynchronous to i_clk
 * and far slower than it, so edges are found after a two-flop synchroniser.
 */
`timescale 1ns/1ps
`include "sram_cfg.svh"

// Contract
// - DLL enabled: first read word follows one and a half cycles after request.
// - DLL disabled: first read word follows one cycle after request.
// - accesses start on positive input clock rise; data on both input rises.
// - every access is a four word burst of 18 bits over two cycles.
// - low read select at input rise starts read and latches the address.
// - after next input rise, words leave lowest first on alternating output rises.
// - read on consecutive input rises is ignored; every other cycle is fine.
// - deselected read port finishes, then outputs float after next positive output rise.
// - low write select starts write; four words captured on following rises.
// - write on consecutive input rises is ignored; every other cycle is fine.
// - deselected write port completes pending write and ignores its inputs.
// - byte selects sampled with each word; only low selects write their byte.
// - select 0 gates bits 8..0, select 1 bits 17..9; both high writes nothing.
// - both output clocks high at power-on select single clock mode, fixed.
// - read after write to same place returns newest data.
// - both selected: read wins after idle or write, write wins after read.
// - selects sampled on positive input rise only; pending work completes.
// - output impedance update repeats every 1024 clock cycles after power up.
// - two free-running echo clocks follow output clocks or the input pair.
// - DLL locks after 1024 stable input clock cycles.
// - power-up leaves both ports deselected and outputs floating.
// - burst words address latched location then next three in increasing order.
module sram_burst (
    input  wire logic                i_clk,
    input  wire logic                i_srst,
    input  wire logic                i_k,
    input  wire logic                i_k_n,
    input  wire logic                i_c,
    input  wire logic                i_c_n,
    input  wire logic                i_read_port_select_n,
    input  wire logic                i_write_port_select_n,
    input  wire logic                i_dll_disable_n,
    input  wire logic [`BE_W-1:0]    i_byte_write_select_n,
    input  wire logic [`ADDR_W-1:0]  i_addr,
    input  wire logic [`WORD_W-1:0]  i_d,
    output logic      [`WORD_W-1:0]  o_q,
    output logic                     o_q_oe,
    output logic                     o_echo_clock,
    output logic                     o_echo_clock_n,
    output logic                     o_dll_locked,
    output logic                     o_imp_update
);

    // ============================================================
    // declarations
    sram_pkg::state_t    st_reg;
    sram_pkg::state_t    st_next;
    sram_pkg::pins_t     pins_in;
    sram_pkg::wr_word_t  wr_new;
    logic                k_rise;
    logic                kn_rise;
    logic                oc_rise;
    logic                ocn_rise;
    logic                dll_on;
    logic                rd_go;
    logic                wr_go;
    logic                head_armed;
    logic                rd_req;
    logic [`MEM_AW-1:0]  rd_addr;
    logic                cap_now;
    logic                push;
    logic                pop;
    logic                in_ready;
    logic                mem_en;
    logic                mem_we;
    logic [`MEM_AW-1:0]  mem_addr;
    logic [`WORD_W-1:0]  mem_rdata;

    // pins gathered in struct field order
    assign pins_in = {i_k, i_k_n, i_c, i_c_n, i_read_port_select_n, i_write_port_select_n,
                      i_dll_disable_n, i_byte_write_select_n, i_addr, i_d};

    // ============================================================
    // next state
    always_comb
    begin
        st_next = st_reg;
        // two-flop synchroniser; only s2 is looked at below
        st_next.s1 = pins_in;
        st_next.s2 = st_reg.s1;
        st_next.k_q = st_reg.s2.k;
        st_next.k_n_q = st_reg.s2.k_n;
        st_next.c_q = st_reg.s2.c;
        st_next.c_n_q = st_reg.s2.c_n;
        k_rise = st_reg.s2.k & ~st_reg.k_q;
        kn_rise = st_reg.s2.k_n & ~st_reg.k_n_q;
        // single clock mode times the outputs from the input pair
        oc_rise = st_reg.single_mode ? k_rise : (st_reg.s2.c & ~st_reg.c_q);
        ocn_rise = st_reg.single_mode ? kn_rise : (st_reg.s2.c_n & ~st_reg.c_n_q);
        dll_on = st_reg.s2.dll_disable_n;

        // selects only count at a positive input rise
        // back-to-back requests of one kind are dropped
        // contention: read first unless a read just started
        rd_go = k_rise & ~st_reg.s2.read_port_select_n & (st_reg.last_op != sram_pkg::OP_READ);
        wr_go = k_rise & ~st_reg.s2.write_port_select_n & ~rd_go
              & (st_reg.last_op != sram_pkg::OP_WRITE);
        if (k_rise)
        begin
            st_next.last_op = rd_go ? sram_pkg::OP_READ
                            : (wr_go ? sram_pkg::OP_WRITE : sram_pkg::OP_IDLE);
        end

        // a queued read becomes due at the input rise after its request
        if (k_rise && st_reg.rd0.valid)
        begin
            st_next.rd0.armed = 1'b1;
        end
        if (k_rise && st_reg.rd1.valid)
        begin
            st_next.rd1.armed = 1'b1;
        end
        head_armed = st_reg.rd0.armed | (k_rise & st_reg.rd0.valid);

        // word fetch per output rise: DLL mode opens on the negative output rise,
        // legacy mode on the positive one, then they alternate
        rd_req = 1'b0;
        rd_addr = {st_reg.rd0.addr, st_reg.rd0.idx}; // latched address, then +1..+3
        if (st_reg.rd0.valid && head_armed)
        begin
            if ((!st_reg.rd0.started && (dll_on ? ocn_rise : oc_rise))
                || (st_reg.rd0.started && (oc_rise || ocn_rise)))
            begin
                rd_req = 1'b1;
                st_next.rd0.started = 1'b1;
                st_next.rd0.idx = st_reg.rd0.idx + 2'h1;
                if (st_reg.rd0.idx == 2'h3)
                begin
                    st_next.rd0 = st_next.rd1; // burst of four done
                    st_next.rd1 = '0;
                end
            end
        end
        if (rd_go)
        begin
            if (!st_next.rd0.valid)
            begin
                st_next.rd0 = '{valid: 1'b1, armed: 1'b0, started: 1'b0, idx: 2'h0,
                                addr: st_reg.s2.addr};
            end
            else
            begin
                st_next.rd1 = '{valid: 1'b1, armed: 1'b0, started: 1'b0, idx: 2'h0,
                                addr: st_reg.s2.addr};
            end
        end

        // write words: even ones on input rise, odd ones on negative input rise
        // nothing is captured without an open write slot
        cap_now = st_reg.wr0.valid & (st_reg.wr0.idx[0] ? kn_rise : k_rise);
        wr_new.addr = {st_reg.wr0.addr, st_reg.wr0.idx};
        wr_new.be = ~st_reg.s2.byte_write_select_n; // lane 0 = bits 8..0
        wr_new.data = st_reg.s2.d;
        in_ready = (st_reg.buf_cnt != `BUF_DEPTH);
        push = cap_now & (|wr_new.be) & in_ready;
        if (cap_now)
        begin
            st_next.wr0.idx = st_reg.wr0.idx + 2'h1;
            if (st_reg.wr0.idx == 2'h3)
            begin
                st_next.wr0 = st_reg.wr1;
                st_next.wr1 = '0;
            end
        end
        if (wr_go)
        begin
            if (!st_next.wr0.valid)
            begin
                st_next.wr0 = '{valid: 1'b1, idx: 2'h0, addr: st_reg.s2.addr};
            end
            else
            begin
                st_next.wr1 = '{valid: 1'b1, idx: 2'h0, addr: st_reg.s2.addr};
            end
        end

        // two-entry buffer; the array port stalls it while a read fetch runs.
        // words land long before the read that wants them, so the array itself
        // serves as the forwarding path
        pop = (st_reg.buf_cnt != 2'h0) & ~rd_req;
        if (pop)
        begin
            st_next.buf0 = st_reg.buf1;
            st_next.buf_cnt = st_reg.buf_cnt - 2'h1;
        end
        if (push)
        begin
            if (st_next.buf_cnt == 2'h0)
            begin
                st_next.buf0 = wr_new;
            end
            else
            begin
                st_next.buf1 = wr_new;
            end
            st_next.buf_cnt = st_next.buf_cnt + 2'h1;
        end
        mem_en = rd_req | pop;
        mem_we = pop;
        mem_addr = rd_req ? rd_addr : st_reg.buf0.addr;

        // output register; floats at the first positive output rise with nothing to send
        st_next.emit = rd_req;
        if (st_reg.emit)
        begin
            st_next.q = mem_rdata;
            st_next.q_oe = 1'b1;
        end
        else if (oc_rise && !rd_req)
        begin
            st_next.q = '0;
            st_next.q_oe = 1'b0;
        end

        // echo clocks follow whichever pair times the outputs
        st_next.echo = st_reg.single_mode ? st_reg.s2.k : st_reg.s2.c;
        st_next.echo_n = st_reg.single_mode ? st_reg.s2.k_n : st_reg.s2.c_n;

        // lock counts input rises; losing the enable restarts it
        if (!dll_on)
        begin
            st_next.dll_cnt = '0;
            st_next.dll_locked = 1'b0;
        end
        else if (k_rise && !st_reg.dll_locked)
        begin
            st_next.dll_cnt = st_reg.dll_cnt + 10'h001;
            st_next.dll_locked = (st_reg.dll_cnt == `DLL_LOCK_LAST);
        end

        // impedance refresh strobe once per wrap of the counter
        st_next.imp_pulse = k_rise & (st_reg.imp_cnt == `IMP_UPD_LAST);
        if (k_rise)
        begin
            st_next.imp_cnt = st_reg.imp_cnt + 10'h001;
        end

        // reset: ports idle, outputs floating; strap caught while held
        if (i_srst)
        begin
            st_next = '0;
            st_next.s1 = pins_in;
            st_next.s2 = st_reg.s1;
            st_next.single_mode = st_reg.s2.c & st_reg.s2.c_n;
        end
    end

    // ============================================================
    // state register
    always_ff @(posedge i_clk)
    begin
        st_reg <= st_next;
    end

    // ============================================================
    // storage
    sram_array u_array (
        .i_clk   (i_clk),
        .i_en    (mem_en),
        .i_we    (mem_we),
        .i_addr  (mem_addr),
        .i_be    (st_reg.buf0.be),
        .i_wdata (st_reg.buf0.data),
        .o_rdata (mem_rdata)
    );

    // outputs straight from the state register
    assign o_q = st_reg.q;
    assign o_q_oe = st_reg.q_oe;
    assign o_echo_clock = st_reg.echo;
    assign o_echo_clock_n = st_reg.echo_n;
    assign o_dll_locked = st_reg.dll_locked;
    assign o_imp_update = st_reg.imp_pulse;

    // ============================================================
    // checks
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_srst);

    sequence s_idle_out_rise;
        !st_reg.rd0.valid && !st_reg.emit && oc_rise;
    endsequence

    sequence s_both_after_read;
        k_rise && !st_reg.s2.read_port_select_n && !st_reg.s2.write_port_select_n
        && st_reg.last_op == sram_pkg::OP_READ;
    endsequence

    chk_read_pair_drop: assert property (
        k_rise && st_reg.last_op == sram_pkg::OP_READ |-> !rd_go)
        else $error("read accepted on back-to-back input rises");
    chk_arb_after_read: assert property (
        s_both_after_read |=> st_reg.last_op == sram_pkg::OP_WRITE)
        else $error("write did not win after a read");
    chk_start_on_k: assert property ((rd_go || wr_go) |-> k_rise)
        else $error("access started away from an input rise");
    chk_dll_first_word: assert property (
        rd_req && !st_reg.rd0.started && dll_on |-> ocn_rise)
        else $error("dll mode first word not on negative output rise");
    chk_legacy_first_word: assert property (
        rd_req && !st_reg.rd0.started && !dll_on |-> oc_rise)
        else $error("legacy first word not on positive output rise");
    chk_emit_data: assert property (
        st_reg.emit |=> st_reg.q_oe && st_reg.q == $past(mem_rdata))
        else $error("fetched word not driven out");
    chk_idle_float: assert property (s_idle_out_rise |=> !st_reg.q_oe)
        else $error("outputs driven with no read pending");
    chk_byte_mask: assert property (push |-> wr_new.be == ~st_reg.s2.byte_write_select_n)
        else $error("byte lanes do not follow the selects");
    chk_write_ignore: assert property (!st_reg.wr0.valid |-> !push)
        else $error("write word captured with no write open");
    chk_strap_fixed: assert property (1'b1 |=> $stable(st_reg.single_mode))
        else $error("clock mode changed during operation");
    chk_dll_lock_count: assert property (
        $rose(st_reg.dll_locked) |-> st_reg.dll_cnt == 10'h000)
        else $error("lock not reached after the full count");

endmodule

// ===== testbench/ctrl_model.sv
/*
 * Memory controller model: link clocks, port selects, address, write data.
 * Assumes the bench calls its tasks one access at a time or in a fork.
 */
`timescale 1ns/1ps
`include "sram_cfg.svh"

module ctrl_model (
    input  wire logic                i_clk,
    input  wire logic                i_single,
    output logic                     o_k,
    output logic                     o_k_n,
    output logic                     o_c,
    output logic                     o_c_n,
    output logic                     o_rd_n,
    output logic                     o_wr_n,
    output logic [`BE_W-1:0]         o_bws_n,
    output logic [`ADDR_W-1:0]       o_addr,
    output logic [`WORD_W-1:0]       o_d
);
    // ============================================================
    // time base
    logic ph;
    logic qph;

    // qph edges sit mid-phase, far from every clock rise
    initial
    begin
        ph = 1'b0;
        qph = 1'b0;
        {o_rd_n, o_wr_n, o_bws_n} = 4'hF;
        o_addr = '0;
        o_d = '0;
        #31.25;
        forever #62.5 qph = ~qph;
    end

    // free running and never stopped, so only reset or a low DLL enable clears the lock; the fixed
    // bench period sits below the lock range, which the design does not
    always #62.5 ph = ~ph;

    // clocks reach the pins on the system clock; output pair tied high as strap while i_single is set
    always @(posedge i_clk)
    begin
        o_k <= ph;
        o_k_n <= ~ph;
        o_c <= i_single | ph;
        o_c_n <= i_single | ~ph;
    end

    // ============================================================
    // requests: selects change only between input rises
    task automatic cmd(input logic rd_n, input logic wr_n, input logic [`ADDR_W-1:0] a);
        @(negedge qph);
        @(posedge i_clk);
        o_rd_n <= rd_n;
        o_wr_n <= wr_n;
        o_addr <= (rd_n & wr_n) ? ~o_addr : a;
    endtask

    // four words on k, k_n, k, k_n after the request rise
    task automatic wdata(input logic [71:0] w, input logic [7:0] be_n);
        @(negedge qph);
        for (int i = 0; i < 4; i++)
        begin
            if (i % 2 == 0)
                @(negedge qph);
            else
                @(posedge qph);
            @(posedge i_clk);
            o_d <= w[i*`WORD_W +: `WORD_W];
            o_bws_n <= be_n[i*2 +: 2];
        end
        @(negedge qph);
        @(posedge i_clk);
        o_d <= ~o_d;   // released lines must not keep the last word
        o_bws_n <= 2'h0;
    endtask
endmodule

// ===== testbench/tb.sv
/*
 * Self-checking bench of the burst SRAM: bursts, byte masks, refusals,
 * forwarding, contention, latency modes, pacing counts and echo clocks.
 * Assumes the design files and ctrl_model are compiled before it.
 */
`timescale 1ns/1ps
`include "sram_cfg.svh"

module tb;
    localparam logic [18:0] A_LOC = 19'h00010;
    localparam logic [18:0] B_LOC = 19'h7FFFE;
    localparam logic [71:0] D1 = 72'h123456789ABCDEF012;
    localparam logic [71:0] D2 = 72'hFEDCBA9876543210ED;
    localparam logic [71:0] D3 = 72'h0F0F0F0F0F0F0F0F0F;
    localparam logic [71:0] D4 = 72'hA5A5A5A5A5A5A5A5A5;
    localparam logic [71:0] D6 = 72'h3C3C3C3C3C3C3C3C3C;
    localparam logic [71:0] D7 = 72'h5A5A5A5A5A5A5A5A5A;

    logic                       i_clk = 1'b0;
    logic                       i_srst = 1'b1;
    logic                       dll_n = 1'b0;
    logic                       single = 1'b0;
    logic                       k, k_n, c, c_n, rd_n, wr_n;
    logic [`BE_W-1:0]           bws_n;
    logic [`ADDR_W-1:0]         addr;
    logic [`WORD_W-1:0]         d, q;
    logic                       q_oe, echo, echo_n, locked, imp;
    int                         error_cnt, comparisons, qe, kr, imp_at, gap, pulses;
    logic [`WORD_W-1:0]         rq[$];
    int                         rt[$];

    always #4 i_clk = ~i_clk;

    sram_burst uut (
        .i_clk                 (i_clk),
        .i_srst                (i_srst),
        .i_k                   (k),
        .i_k_n                 (k_n),
        .i_c                   (c),
        .i_c_n                 (c_n),
        .i_read_port_select_n  (rd_n),
        .i_write_port_select_n (wr_n),
        .i_dll_disable_n       (dll_n),
        .i_byte_write_select_n (bws_n),
        .i_addr                (addr),
        .i_d                   (d),
        .o_q                   (q),
        .o_q_oe                (q_oe),
        .o_echo_clock          (echo),
        .o_echo_clock_n        (echo_n),
        .o_dll_locked          (locked),
        .o_imp_update          (imp)
    );

    ctrl_model ctrl (
        .i_clk    (i_clk),
        .i_single (single),
        .o_k      (k),
        .o_k_n    (k_n),
        .o_c      (c),
        .o_c_n    (c_n),
        .o_rd_n   (rd_n),
        .o_wr_n   (wr_n),
        .o_bws_n  (bws_n),
        .o_addr   (addr),
        .o_d      (d)
    );

    // ============================================================
    // monitors: read words sampled at each link edge, half a phase after launch
    always @(ctrl.ph)
    begin
        qe++;
        if (q_oe === 1'b1)
        begin
            rq.push_back(q);
            rt.push_back(qe);
        end
    end

    always @(posedge ctrl.ph)
        kr++;

    always @(posedge i_clk)
    begin
        if (imp === 1'b1)
        begin
            gap = kr - imp_at;
            imp_at = kr;
            pulses++;
        end
    end

    // ============================================================
    // shared tasks
    task automatic cmp(input logic [71:0] got, input logic [71:0] exp, input string msg);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask

    task automatic final_report();
        if (error_cnt == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    function automatic logic [71:0] merge(input logic [71:0] o, input logic [71:0] w,
                                          input logic [7:0] be_n);
        logic [71:0] r;
        r = o;
        for (int i = 0; i < 8; i++)
            if (!be_n[i])
                r[i*9 +: 9] = w[i*9 +: 9];
        return r;
    endfunction

    task automatic reset();
        @(posedge i_clk);
        i_srst <= 1'b1;
        repeat (6) @(posedge i_clk);
        i_srst <= 1'b0;
        repeat (4) @(posedge i_clk);
    endtask

    // n counts link edges at the request; first word seen 4 or 5 edges later.
    // with the dll on the last word stands a whole cycle, so it is seen twice
    task automatic burst(input int n, input logic [71:0] w);
        int lat;
        lat = (dll_n === 1'b1) ? 5 : 4;
        while (qe < n + lat + 5)
            @(ctrl.ph);
        cmp(72'(rq.size()), 72'(lat), "burst word count");
        if (rq.size() == lat)
        begin
            cmp(72'(rt[0]), 72'(n + lat), "first word edge");
            cmp({rq[3], rq[2], rq[1], rq[0]}, w, "burst data");
        end
        cmp(72'(q_oe), 72'h0, "outputs float after burst");
        rq.delete();
        rt.delete();
    endtask

    task automatic wr(input logic [18:0] a, input logic [71:0] w, input logic [7:0] be_n);
        fork
            begin
                ctrl.cmd(1'b1, 1'b0, a);
                ctrl.cmd(1'b1, 1'b1, '0);
            end
            ctrl.wdata(w, be_n);
        join
    endtask

    task automatic rd(input logic [18:0] a, input logic [71:0] w);
        int n;
        rq.delete();
        rt.delete();
        ctrl.cmd(1'b0, 1'b1, a);
        n = qe;
        ctrl.cmd(1'b1, 1'b1, '0);
        burst(n, w);
    endtask

    task automatic t_echo();
        repeat (8)
        begin
            @(ctrl.qph);
            #20;
            cmp(72'({echo, echo_n}), 72'({ctrl.ph, ~ctrl.ph}), "echo level");
        end
    endtask

    // ============================================================
    // scenarios
    task automatic t_idle();
        cmp(72'(q_oe), 72'h0, "floating after reset");
        repeat (8) @(ctrl.qph);
        cmp(72'(rq.size()), 72'h0, "no output while idle");
    endtask

    task automatic t_bytes();
        wr(A_LOC, D1, 8'h00);
        rd(A_LOC, D1);
        wr(A_LOC, D2, 8'hE4);
        rd(A_LOC, merge(D1, D2, 8'hE4));
    endtask

    task automatic t_refuse();
        int n;
        wr(B_LOC, D3, 8'h00);
        fork
            begin
                ctrl.cmd(1'b1, 1'b0, A_LOC);
                ctrl.cmd(1'b1, 1'b0, B_LOC);
                ctrl.cmd(1'b1, 1'b1, '0);
            end
            ctrl.wdata(D4, 8'h00);
        join
        rd(B_LOC, D3);
        ctrl.cmd(1'b0, 1'b1, A_LOC);
        n = qe;
        ctrl.cmd(1'b0, 1'b1, B_LOC);
        ctrl.cmd(1'b1, 1'b1, '0);
        burst(n, D4);
    endtask

    task automatic t_forward();
        int n;
        fork
            begin
                ctrl.cmd(1'b1, 1'b0, A_LOC);
                ctrl.cmd(1'b0, 1'b1, A_LOC);
                n = qe;
                ctrl.cmd(1'b1, 1'b1, '0);
            end
            ctrl.wdata(D6, 8'h00);
        join
        burst(n, D6);
    endtask

    task automatic t_arbit();
        int n;
        fork
            begin
                ctrl.cmd(1'b0, 1'b0, A_LOC);
                n = qe;
                ctrl.cmd(1'b0, 1'b0, B_LOC);
                ctrl.cmd(1'b1, 1'b1, '0);
            end
            begin
                @(negedge ctrl.qph);
                ctrl.wdata(D7, 8'h00);
            end
        join
        burst(n, D6);
        rd(B_LOC, D7);
    endtask

    task automatic t_dll();
        int k0;
        @(posedge i_clk);
        dll_n <= 1'b1;
        k0 = kr;
        while (locked !== 1'b1 && kr - k0 < 1100)
            @(posedge i_clk);
        cmp(72'(kr - k0 > 1022 && kr - k0 < 1027), 72'h1, "lock after 1024 rises");
        rd(A_LOC, D6);
    endtask

    task automatic t_imp();
        int p0;
        p0 = pulses;
        repeat (2100)
        begin
            if (pulses >= p0 + 2)
                break;
            @(posedge ctrl.ph);
        end
        cmp(72'(gap), 72'h400, "impedance update spacing");
    endtask

    task automatic t_single();
        t_echo();
        @(posedge i_clk);
        single <= 1'b1;
        reset();
        t_echo();
        rd(A_LOC, D6);
    endtask

    // ============================================================
    // main sequence and watchdog
    initial
    begin
        reset();
        t_idle();
        t_bytes();
        t_refuse();
        t_forward();
        t_arbit();
        t_dll();
        t_imp();
        t_single();
        final_report();
    end

    // about 400 us of traffic expected; allow well beyond it
    initial
    begin
        #700000;
        error_cnt++;
        final_report();
    end
endmodule
